// file: logic/dscp_host.sv
// The APB slave port was chosen for this implementation.
module dscp_host
  import dscp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  dscp_if.host link
);
  dscp_host_state_t state_ff;
  logic [4:0] cnt_ff;
  logic [4:0] bit_ff;
  logic [4:0] nbits_ff;
  logic [31:0] tx_ff;
  logic [7:0] rx_ff;
  logic [7:0] rdata_ff;
  logic [2:0] cfg_ff;
  logic rd_ff;
  logic rec_ff;
  logic sclk_ff;
  logic cs_n_ff;
  logic oe_ff;
  logic sdio_s1_ff;
  logic sdio_s2_ff;
  logic sdo_s1_ff;
  logic sdo_s2_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;

  wire setup = i_psel & ~i_penable;
  wire access = i_psel & i_penable & pready_ff;
  wire idle = state_ff == DSCP_IDLE;
  wire wr_cmd = access & i_pwrite & (i_paddr == HOST_CMD_OFS) & idle;
  wire wr_cfg = access & i_pwrite & (i_paddr == HOST_CFG_OFS);
  wire wr_rec = access & i_pwrite & (i_paddr == HOST_RECOVER_OFS) & idle;
  wire lsb = cfg_ff[HCFG_LSB_BIT];
  wire mapped = (i_paddr == HOST_CMD_OFS) | (i_paddr == HOST_CFG_OFS) |
                (i_paddr == HOST_STATUS_OFS) | (i_paddr == HOST_RECOVER_OFS);
  wire [31:0] status_word = {16'h0000, rdata_ff, 7'h00, ~idle};
  wire [31:0] rd_mux = (i_paddr == HOST_CFG_OFS) ? {29'h0, cfg_ff} :
                       (i_paddr == HOST_STATUS_OFS) ? status_word : 32'h0;
  wire [7:0] instr = {i_pwdata[CMD_READ_BIT], i_pwdata[14:CMD_ADDR_LSB]};
  wire [2:0] part = (i_pwdata[2:0] == 3'h0) ? 3'h1 : i_pwdata[2:0];
  wire rx_line = cfg_ff[HCFG_FOUR_WIRE_BIT] ? sdo_s2_ff : sdio_s2_ff;
  wire data_phase = bit_ff >= 5'(INSTR_LAST_BIT + 4'h1);
  wire last_bit = bit_ff == nbits_ff - 5'h1;
  wire stall_here = cfg_ff[HCFG_STALL_BIT] & ~rec_ff &
                    (bit_ff == 5'(INSTR_LAST_BIT));

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff <= setup ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_ff <= HCFG_RESET;
    end else if (wr_cfg) begin
      cfg_ff <= i_pwdata[2:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sdio_s1_ff <= 1'b1;
      sdio_s2_ff <= 1'b1;
      sdo_s1_ff <= 1'b1;
      sdo_s2_ff <= 1'b1;
    end else begin
      sdio_s1_ff <= link.sdio_line;
      sdio_s2_ff <= sdio_s1_ff;
      sdo_s1_ff <= link.sdo_line;
      sdo_s2_ff <= sdo_s1_ff;
    end
  end

  // Serial engine; half period well above the 20 MHz floor
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= DSCP_IDLE;
      cnt_ff <= 5'h00;
      bit_ff <= 5'h00;
      nbits_ff <= FRAME_BITS;
      tx_ff <= 32'h0;
      rx_ff <= 8'h00;
      rdata_ff <= 8'h00;
      rd_ff <= 1'b0;
      rec_ff <= 1'b0;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      oe_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        DSCP_IDLE: begin
          cnt_ff <= 5'h00;
          bit_ff <= 5'h00;
          if (wr_cmd) begin
            tx_ff <= {dscp_order(instr, lsb),
                      dscp_order(i_pwdata[7:0], lsb), 16'h0000};
            nbits_ff <= FRAME_BITS;
            rd_ff <= i_pwdata[CMD_READ_BIT];
            rec_ff <= 1'b0;
            cs_n_ff <= 1'b0;
            oe_ff <= 1'b1;
            state_ff <= DSCP_LOW;
          end else if (wr_rec) begin
            tx_ff <= 32'h0;
            nbits_ff <= RECOVER_ZERO_BITS + {2'b00, part};
            rd_ff <= 1'b0;
            rec_ff <= 1'b1;
            cs_n_ff <= 1'b0;
            oe_ff <= 1'b1;
            state_ff <= DSCP_LOW;
          end
        end
        DSCP_LOW: begin
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == HALF_LAST) begin
            if (rd_ff & data_phase) begin
              rx_ff <= {rx_ff[6:0], rx_line};
            end
            cnt_ff <= 5'h00;
            sclk_ff <= 1'b1;
            state_ff <= DSCP_HIGH;
          end
        end
        DSCP_HIGH: begin
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == HALF_LAST) begin
            cnt_ff <= 5'h00;
            sclk_ff <= 1'b0;
            bit_ff <= bit_ff + 5'h01;
            tx_ff <= {tx_ff[30:0], 1'b0};
            if (rd_ff & (bit_ff == 5'(INSTR_LAST_BIT))) begin
              oe_ff <= 1'b0;
            end
            if (last_bit) begin
              state_ff <= DSCP_END;
            end else if (stall_here) begin
              cs_n_ff <= 1'b1;
              state_ff <= DSCP_STALL;
            end else begin
              state_ff <= DSCP_LOW;
            end
          end
        end
        DSCP_STALL: begin
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == STALL_LAST) begin
            cnt_ff <= 5'h00;
            cs_n_ff <= 1'b0;
            state_ff <= DSCP_LOW;
          end
        end
        DSCP_END: begin
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == HALF_LAST) begin
            cs_n_ff <= 1'b1;
            oe_ff <= 1'b0;
            if (rd_ff) begin
              rdata_ff <= dscp_order(rx_ff, lsb);
            end
            state_ff <= DSCP_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sclk = sclk_ff;
  assign link.cs_n = cs_n_ff;
  assign link.host_sdio_out = tx_ff[31];
  assign link.host_sdio_oe = oe_ff;
  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
endmodule : dscp_host

// file: logic/dscp_pkg.sv
package dscp_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int SCLK_MAX_HZ = 20_000_000;
  // Least half period at the fastest legal serial clock, rounded up
  localparam int SCLK_MIN_HALF = (CLK_HZ + 2 * SCLK_MAX_HZ - 1)
                                 / (2 * SCLK_MAX_HZ);
  // Extra cycles cover two synchronisers and the output flop of each end
  localparam int SCLK_HALF_MARGIN = 7;
  localparam int SCLK_HALF = SCLK_MIN_HALF + SCLK_HALF_MARGIN;
  localparam logic [4:0] HALF_LAST = 5'(SCLK_HALF - 1);
  localparam logic [4:0] STALL_LAST = 5'(2 * SCLK_HALF - 1);
  localparam logic [3:0] INSTR_LAST_BIT = 4'h7;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] RECOVER_ZERO_BITS = 5'h18;
  localparam int NUM_REGS = 8;
  localparam int REG_IDX_W = 3;
  localparam logic [6:0] SPCFG_ADDR = 7'h00;
  localparam int CFG_PIN_MODE_BIT = 7;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam int CFG_DEFAULTS_RESET_BIT = 5;
  localparam int INSTR_READ_BIT = 7;
  localparam logic [7:0] SPCFG_RESET = 8'h80;
  localparam logic [7:0] REG_DEFAULT = 8'h00;
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_CFG_OFS = 8'h04;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h08;
  localparam logic [7:0] HOST_RECOVER_OFS = 8'h0c;
  localparam int CMD_READ_BIT = 15;
  localparam int CMD_ADDR_LSB = 8;
  localparam int HCFG_LSB_BIT = 0;
  localparam int HCFG_FOUR_WIRE_BIT = 1;
  localparam int HCFG_STALL_BIT = 2;
  localparam logic [2:0] HCFG_RESET = 3'h0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDATA_LSB = 8;

  typedef enum {
    DSCP_IDLE, DSCP_LOW, DSCP_HIGH, DSCP_STALL, DSCP_END
  } dscp_host_state_t;

  // Maps a byte between wire order and register order
  function automatic logic [7:0] dscp_order(input logic [7:0] b,
                                            input logic lsb_first);
    logic [7:0] r;
    r = b;
    if (lsb_first) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = b[7 - i];
      end
    end
    return r;
  endfunction : dscp_order
endpackage : dscp_pkg

// file: logic/dscp_if.sv
interface dscp_if;
  logic sclk;
  logic cs_n;
  logic host_sdio_out;
  logic host_sdio_oe;
  logic dev_sdio_out;
  logic dev_sdio_oe;
  logic dev_sdo_out;
  logic dev_sdo_oe;
  logic sdio_line;
  logic sdo_line;

  // Undriven lines read high, as with a pull-up
  assign sdio_line = dev_sdio_oe ? dev_sdio_out :
                     (host_sdio_oe ? host_sdio_out : 1'b1);
  assign sdo_line = dev_sdo_oe ? dev_sdo_out : 1'b1;

  modport device (
    input sclk, cs_n, sdio_line,
    output dev_sdio_out, dev_sdio_oe, dev_sdo_out, dev_sdo_oe
  );
  modport host (
    output sclk, cs_n, host_sdio_out, host_sdio_oe,
    input sdio_line, sdo_line
  );
endinterface : dscp_if

// file: logic/dscp_device.sv
// What this block does
// - First eight rising edges carry the instruction
// - Exactly one data byte follows each instruction
// - Register updates on last written data bit
// - Chip select high at byte boundary pauses
// - Chip select high mid-byte resets port
// - Instruction bit 7 set means read
// - Instruction bits 6..0 select the register
// - Input bits sampled on serial clock rise
// - Host keeps serial clock at most 20 MHz
// - Both data pins released while deselected
// - Host holds chip select low per cycle
// - Config bit 7 chooses shared or split pins
// - Shared pin mode never drives the SDO pin
// - Config bit 6 chooses LSB-first order
// - Config bit 5 restores other register defaults
// - Partial zeros plus three zero bytes recover
// - Host releases data pin before read data
// - Read data starts after a falling edge
// - Host samples read bit before rising edge
// - Separate chip selects, no daisy chain
module dscp_device
  import dscp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  dscp_if.device link,
  output logic [7:0] o_serial_port_config,
  output logic [NUM_REGS*8-1:0] o_reg_bank,
  output logic o_reg_write
);
  logic sclk_s1_ff;
  logic sclk_s2_ff;
  logic sclk_d_ff;
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_d_ff;
  logic sdi_s1_ff;
  logic sdi_s2_ff;
  logic [3:0] cnt_ff;
  logic [6:0] sh_ff;
  logic [7:0] instr_ff;
  logic [7:0] tx_ff;
  logic armed_ff;
  logic out_bit_ff;
  logic sdio_oe_ff;
  logic sdo_oe_ff;
  logic wr_pulse_ff;
  logic [7:0] regs_ff [NUM_REGS];

  // Synchronisers; the first stage is never looked at, only the second stage and its delayed copy
  // Clock and select reset to the idle level of each pin, so no false edge follows reset
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_s1_ff <= link.sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_d_ff <= sclk_s2_ff;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_d_ff <= 1'b1;
    end else begin
      cs_s1_ff <= link.cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_d_ff <= cs_s2_ff;
    end
  end

  // Same latency as the clock path, so data and edge stay aligned
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sdi_s1_ff <= 1'b0;
      sdi_s2_ff <= 1'b0;
    end else begin
      sdi_s1_ff <= link.sdio_line;
      sdi_s2_ff <= sdi_s1_ff;
    end
  end

  wire sclk_rise = sclk_s2_ff & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s2_ff & sclk_d_ff;
  wire cs_active = ~cs_s2_ff;
  wire cs_rise = cs_s2_ff & ~cs_d_ff;
  wire lsb_first = regs_ff[0][CFG_LSB_FIRST_BIT];
  wire pin_shared = regs_ff[0][CFG_PIN_MODE_BIT];
  wire take = sclk_rise & cs_active;
  // Arrival order folded into register order
  wire [7:0] byte_in = dscp_order({sh_ff, sdi_s2_ff}, lsb_first);
  wire instr_done = take & (cnt_ff == INSTR_LAST_BIT);
  wire data_done = take & (cnt_ff == FRAME_LAST_BIT);
  wire mid_byte_stop = cs_rise & (cnt_ff[2:0] != 3'h0);
  wire [6:0] acc_addr = instr_done ? byte_in[6:0] : instr_ff[6:0];
  // Unmapped addresses drop writes and read as zero
  wire addr_hit = acc_addr < 7'(NUM_REGS);
  wire [REG_IDX_W-1:0] acc_idx = acc_addr[REG_IDX_W-1:0];
  wire [7:0] rd_val = addr_hit ? regs_ff[acc_idx] : 8'h00;
  wire is_write = ~instr_ff[INSTR_READ_BIT];
  wire wr_hit = data_done & is_write & addr_hit;
  wire wr_cfg = wr_hit & (acc_addr == SPCFG_ADDR);
  wire defaults = wr_cfg & byte_in[CFG_DEFAULTS_RESET_BIT];
  wire [7:0] cfg_keep_mask = ~(8'h01 << CFG_DEFAULTS_RESET_BIT);
  wire drive = cs_active & armed_ff & instr_ff[INSTR_READ_BIT];

  // Bit counter runs across frames while selected
  // It wraps at sixteen, so a held select starts a new frame
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_ff <= 4'h0;
    end else if (mid_byte_stop) begin
      cnt_ff <= 4'h0;
    end else if (take) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sh_ff <= 7'h00;
    end else if (take) begin
      sh_ff <= {sh_ff[5:0], sdi_s2_ff};
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      instr_ff <= 8'h00;
      tx_ff <= 8'h00;
    end else if (instr_done) begin
      instr_ff <= byte_in;
      tx_ff <= dscp_order(rd_val, lsb_first);
    end
  end

  // Output starts only once a falling edge is seen in the data phase
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      armed_ff <= 1'b0;
    end else if (mid_byte_stop | data_done) begin
      armed_ff <= 1'b0;
    end else if (sclk_fall & cnt_ff[3]) begin
      armed_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      out_bit_ff <= 1'b0;
    end else if (sclk_fall & cnt_ff[3]) begin
      out_bit_ff <= tx_ff[~cnt_ff[2:0]];
    end
  end

  // Enables follow the synchronised select, three cycles behind the pin
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sdio_oe_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else begin
      sdio_oe_ff <= drive & pin_shared;
      sdo_oe_ff <= drive & ~pin_shared;
    end
  end

  // Writes land on the last data bit, no commit step
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      regs_ff[0] <= SPCFG_RESET;
      for (int i = 1; i < NUM_REGS; i++) begin
        regs_ff[i] <= REG_DEFAULT;
      end
    end else if (wr_cfg) begin
      regs_ff[0] <= byte_in & cfg_keep_mask;
      if (defaults) begin
        for (int i = 1; i < NUM_REGS; i++) begin
          regs_ff[i] <= REG_DEFAULT;
        end
      end
    end else if (wr_hit) begin
      regs_ff[acc_idx] <= byte_in;
    end
  end

  // Pulse rises on the same edge that loads the register, not a cycle after it
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pulse_ff <= 1'b0;
    end else begin
      wr_pulse_ff <= wr_hit;
    end
  end

  assign link.dev_sdio_out = out_bit_ff;
  assign link.dev_sdo_out = out_bit_ff;
  assign link.dev_sdio_oe = sdio_oe_ff;
  assign link.dev_sdo_oe = sdo_oe_ff;
  assign o_serial_port_config = regs_ff[0];
  assign o_reg_write = wr_pulse_ff;
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_bank
    assign o_reg_bank[g*8 +: 8] = regs_ff[g];
  end
endmodule : dscp_device

// file: tb/dscp_link_asserts.sv
module dscp_link_asserts (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_sdio_out,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_out,
  input wire logic dev_sdio_oe,
  input wire logic dev_sdo_out,
  input wire logic dev_sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Read drive span; eight bits at ten clocks a half is about 160 clocks
  int oe_cnt_ff;
  int nxt_oe_cnt;
  assign nxt_oe_cnt = (dev_sdio_oe || dev_sdo_oe) ? oe_cnt_ff + 1 : 0;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oe_cnt_ff <= 0;
    end else begin
      oe_cnt_ff <= nxt_oe_cnt;
    end
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  a_idle_pins_released: assert property (cs_n [*6] |->
    !dev_sdio_oe && !dev_sdo_oe) else $error("device drives while idle");
  a_one_read_pin: assert property (!(dev_sdio_oe && dev_sdo_oe))
    else $error("both read pins driven");
  a_bus_turnaround: assert property (dev_sdio_oe |-> !host_sdio_oe)
    else $error("data pin contention");
  a_read_starts_low: assert property ($rose(dev_sdio_oe) ||
    $rose(dev_sdo_oe) |-> !sclk) else $error("read drive not after fall");
  a_read_bit_settled: assert property ((dev_sdio_oe &&
    $changed(dev_sdio_out)) || (dev_sdo_oe && $changed(dev_sdo_out))
    |-> !sclk) else $error("read bit moved while clock high");
  a_host_bit_stable: assert property (!cs_n && sclk && host_sdio_oe
    |-> $stable(host_sdio_out)) else $error("write bit moved at rise");
  a_sclk_high_min: assert property ($rose(sclk) |-> sclk [*3])
    else $error("serial clock high too short");
  a_sclk_low_min: assert property ($fell(sclk) |-> !sclk [*3])
    else $error("serial clock low too short");
  a_stall_clock_low: assert property ($rose(cs_n) |-> !sclk)
    else $error("select raised with clock high");
  a_read_eight_bits: assert property (oe_cnt_ff <= 165)
    else $error("read drive longer than one byte");

  c_shared_read: cover property ($rose(dev_sdio_oe));
  c_split_read: cover property ($rose(dev_sdo_oe));
  c_select_pause: cover property ($rose(cs_n) ##[1:30] $fell(cs_n));
endmodule : dscp_link_asserts

// file: tb/tb.sv
module tb
  import dscp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_reset_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic reg_wr;
  logic [7:0] paddr, spcfg, exp_cfg;
  logic [31:0] pwdata, prdata, rdat;
  logic [63:0] bank, exp_bank;
  logic [6:0] a;
  int failures, n_compared, seed, n_wr;
  dscp_if link();
  dscp_host dscp_host_i(.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .link(link.host));
  dscp_device dscp_device_i(.i_clock(i_clock), .i_reset_n(i_reset_n),
    .link(link.device), .o_serial_port_config(spcfg), .o_reg_bank(bank),
    .o_reg_write(reg_wr));
  dscp_link_asserts dscp_link_asserts_i(.i_clock(i_clock),
    .i_reset_n(i_reset_n), .sclk(link.sclk), .cs_n(link.cs_n),
    .host_sdio_out(link.host_sdio_out), .host_sdio_oe(link.host_sdio_oe),
    .dev_sdio_out(link.dev_sdio_out), .dev_sdio_oe(link.dev_sdio_oe),
    .dev_sdo_out(link.dev_sdo_out), .dev_sdo_oe(link.dev_sdo_oe));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Counts register write pulses for the per-write check
  always @(posedge i_clock) begin
    if (reg_wr === 1'b1) begin
      n_wr <= n_wr + 1;
    end
  end

  task automatic complete_run;
    $display("Counts: %0d compared, %0d failed", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                     input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    @(posedge i_clock);
    while (pready !== 1'b1) @(posedge i_clock);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Busy is polled, so no frame length is assumed here
  task automatic start_wait(input logic [7:0] ofs, input logic [31:0] d);
    apb(1'b1, ofs, d);
    do apb(1'b0, HOST_STATUS_OFS, 32'h0);
    while (rdat[STAT_BUSY_BIT] === 1'b1);
  endtask : start_wait

  function automatic logic [7:0] exp_rd(input logic [6:0] ad);
    if (ad == SPCFG_ADDR) return exp_cfg;
    if (ad < NUM_REGS) return exp_bank[8 * ad +: 8];
    return 8'h00;
  endfunction : exp_rd

  // Byte 0 of the bank is left out; register 0 is checked on its own port
  task automatic sw(input logic [6:0] ad, input logic [7:0] d);
    int n0;
    n0 = n_wr;
    start_wait(HOST_CMD_OFS, {16'h0, 1'b0, ad, d});
    if (ad == SPCFG_ADDR) begin
      if (d[CFG_DEFAULTS_RESET_BIT]) exp_bank = '0;
      exp_cfg = d & ~(8'h01 << CFG_DEFAULTS_RESET_BIT);
    end else if (ad < NUM_REGS) begin
      exp_bank[8 * ad +: 8] = d;
    end
    chk(bank >> 8, exp_bank >> 8, "bank");
    chk(64'(spcfg), 64'(exp_cfg), "config");
    chk(64'(n_wr - n0), 64'(ad < NUM_REGS), "write pulse");
  endtask : sw

  task automatic sr(input logic [6:0] ad);
    start_wait(HOST_CMD_OFS, {16'h0, 1'b1, ad, 8'h00});
    chk(64'(rdat[15:8]), 64'(exp_rd(ad)), "read");
  endtask : sr

  task automatic host_cfg(input logic [31:0] c);
    apb(1'b1, HOST_CFG_OFS, c);
    apb(1'b0, HOST_CFG_OFS, 32'h0);
    chk(64'(rdat), 64'(c), "host cfg");
  endtask : host_cfg

  // Device order changes first, then the host follows it
  task automatic mode(input logic [7:0] v, input logic stall);
    sw(SPCFG_ADDR, v);
    host_cfg({29'h0, stall, ~v[CFG_PIN_MODE_BIT], v[CFG_LSB_FIRST_BIT]});
  endtask : mode

  initial begin
    repeat (90000) @(posedge i_clock);
    failures++;
    complete_run();
  end

  initial begin
    seed = 64;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    i_reset_n = 1'b0;
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    exp_bank = '0;
    exp_cfg = SPCFG_RESET;
    chk(64'(spcfg), 64'(SPCFG_RESET), "reset config");
    chk(bank >> 8, 64'h0, "reset bank");
    apb(1'b0, 8'h10, 32'h0);
    chk(64'(rerr), 64'h1, "unmapped offset");
    host_cfg(32'h0);
    $display("Test reset done");
    repeat (8) begin
      a = 7'($random(seed)) & 7'h47;
      if (a == SPCFG_ADDR) a = 7'h40;
      sw(a, 8'($random(seed)));
      sr(a);
    end
    $display("Test random access done");
    for (int i = 3; i >= 0; i--) begin
      mode({i[1] ^ i[0], ~i[1], 1'b0, 5'($random(seed))}, i[0]);
      a = 7'(1 + ($random(seed) & 6));
      sw(a, 8'($random(seed)));
      sr(a);
      sr(SPCFG_ADDR);
    end
    $display("Test pin and order modes done");
    mode(8'h80, 1'b0);
    sw(7'h03, 8'h5a);
    sw(SPCFG_ADDR, 8'ha0);
    sr(7'h03);
    sr(SPCFG_ADDR);
    $display("Test register defaults done");
    // A second command while the first is on the link must be dropped
    apb(1'b1, HOST_CMD_OFS, {16'h0, 1'b0, 7'h04, 8'h3c});
    start_wait(HOST_CMD_OFS, {16'h0, 1'b0, 7'h05, 8'hc3});
    exp_bank[39:32] = 8'h3c;
    chk(bank >> 8, exp_bank >> 8, "write while busy");
    $display("Test busy command done");
    for (int k = 0; k < 8; k += 3) begin
      mode(8'hc0, 1'b1);
      sw(7'h02, 8'($random(seed)));
      host_cfg(32'h0);
      start_wait(HOST_RECOVER_OFS, 32'(k));
      exp_cfg = 8'h00;
      chk(64'(spcfg), 64'h0, "recovered config");
      host_cfg(32'h2);
      sr(7'h02);
    end
    $display("Test recovery done");
    complete_run();
  end
endmodule : tb
